//--- dcr_top.sv
`timescale 1ns/100ps
`include "dcr_defines.svh"

// What this block does
// - PLL input divider from config bits 2-0
// - Bit 31 gives bus-power pin to USB
// - Bit 30 gives ID pin to USB
// - Bit 29 makes pin mapping one-shot
// - Bit 28 makes module disable one-shot
// - Hold 16-bit user ID for programmer/test
// - Pin-map lock rejects pin-map writes
// - Module lock rejects module-disable writes
// - Lock changes need the unlock sequence
// - Test port enable bit, resets to one
// - Two-wire test output use, resets one
// - Control unused bits read zero, 2-1 one
// - Read-only revision and identity register
// - Hold execution for regulator start-up delay
// - Apply delay on every resume, sleep too
// - Low supply gives brown-out reset, flag
module dcr_top #(
    parameter logic [3:0] SILICON_REV = 4'h1, // Arbitrary value
    parameter logic [27:0] DEVICE_IDENTITY = 28'h000_0a5a, // Arbitrary value
    parameter int unsigned STARTUP_NS = `DCR_STARTUP_NS,
    parameter int unsigned STARTUP_CYC = (STARTUP_NS + `DCR_CLK_PERIOD_NS - 1) / `DCR_CLK_PERIOD_NS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire dcr_pkg::dcr_reg_req_t reg_req_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic sys_unlocked_i,
    input wire logic [31:0] nv_cfg2_i,
    input wire logic [31:0] nv_cfg3_i,
    input wire dcr_pkg::dcr_lock_req_t lock_req_i,
    output logic pin_map_wr_accept_o,
    output logic module_disable_wr_accept_o,
    output dcr_pkg::dcr_cfg_t cfg_o,
    output logic [15:0] user_identifier_o,
    output logic test_port_enable_o,
    output logic two_wire_test_out_use_o,
    input wire logic supply_low_i,
    output logic brownout_reset_o,
    input wire logic power_resume_i,
    output logic exec_enable_o
);
    import dcr_pkg::*;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------

    // Divider code to ratio; the top two codes jump to 10 and 12
    function automatic logic [3:0] div_ratio(input logic [2:0] sel);
        logic [3:0] r;
        r = 4'h1;
        unique case (sel)
            3'h0: r = 4'h1;
            3'h1: r = 4'h2;
            3'h2: r = 4'h3;
            3'h3: r = 4'h4;
            3'h4: r = 4'h5;
            3'h5: r = 4'h6;
            3'h6: r = 4'ha;
            3'h7: r = 4'hc;
        endcase
        return r;
    endfunction

    function automatic logic hit(input dcr_reg_req_t q, input logic [2:0] idx);
        return q.addr == idx;
    endfunction

    // ----------------------------------------
    // Nonvolatile configuration words
    // ----------------------------------------
    logic cfg_loaded_r;
    logic [31:0] cfg2_r;
    logic [31:0] cfg3_r;

    // Words are caught on the first edge after reset release; a flop
    // under async reset may only take a constant
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_loaded_r <= 1'b0;
        end else begin
            cfg_loaded_r <= 1'b1;
        end
    end

    // No write path reaches these; only programming changes them
    always_ff @(posedge clk_i) begin
        if (!cfg_loaded_r) begin
            cfg2_r <= nv_cfg2_i;
            cfg3_r <= nv_cfg3_i;
        end
    end

    wire [2:0] pll_input_div_sel = cfg2_r[`DCR_CFG2_PLLDIV_LSB +: 3];
    wire usb_power_pin_owner = cfg3_r[`DCR_CFG3_USB_PWR_BIT];
    wire usb_id_pin_owner = cfg3_r[`DCR_CFG3_USB_ID_BIT];
    wire pin_map_single_change = cfg3_r[`DCR_CFG3_PIN_ONCE_BIT];
    wire module_disable_single_change = cfg3_r[`DCR_CFG3_MOD_ONCE_BIT];
    wire [15:0] user_identifier = cfg3_r[15:0];

    // Until the words are loaded, present the safe defaults
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_o <= '0;
            user_identifier_o <= '0;
        end else if (cfg_loaded_r) begin
            cfg_o.pll_input_div_ratio <= div_ratio(pll_input_div_sel);
            cfg_o.usb_power_pin_owner <= usb_power_pin_owner;
            cfg_o.usb_id_pin_owner <= usb_id_pin_owner;
            cfg_o.pin_map_single_change <= pin_map_single_change;
            cfg_o.module_disable_single_change <= module_disable_single_change;
            user_identifier_o <= user_identifier;
        end
    end

    // ----------------------------------------
    // Configuration control register
    // ----------------------------------------
    logic pin_map_lock_r;
    logic module_disable_lock_r;
    logic pin_map_lock_nxt;
    logic module_disable_lock_nxt;
    logic test_port_enable_r;
    logic two_wire_test_out_use_r;

    wire ctrl_wr_w = reg_req_i.wr && hit(reg_req_i, `DCR_IDX_CTRL);
    wire ctrl_lock_wr_w = ctrl_wr_w && sys_unlocked_i;
    wire pin_lock_wdata_w = reg_req_i.wdata[`DCR_CTRL_PIN_LOCK_BIT];
    wire mod_lock_wdata_w = reg_req_i.wdata[`DCR_CTRL_MOD_LOCK_BIT];

    // A one-way lock, once set, refuses to clear until reset
    wire pin_lock_frozen_w = pin_map_single_change && pin_map_lock_r;
    wire mod_lock_frozen_w = module_disable_single_change && module_disable_lock_r;

    // Lock bits move only under the unlock sequence
    always_comb begin
        pin_map_lock_nxt = pin_map_lock_r;
        module_disable_lock_nxt = module_disable_lock_r;
        if (ctrl_lock_wr_w && !pin_lock_frozen_w) begin
            pin_map_lock_nxt = pin_lock_wdata_w;
        end
        if (ctrl_lock_wr_w && !mod_lock_frozen_w) begin
            module_disable_lock_nxt = mod_lock_wdata_w;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_map_lock_r <= 1'(`DCR_CTRL_RST >> `DCR_CTRL_PIN_LOCK_BIT);
            module_disable_lock_r <= 1'(`DCR_CTRL_RST >> `DCR_CTRL_MOD_LOCK_BIT);
        end else begin
            pin_map_lock_r <= pin_map_lock_nxt;
            module_disable_lock_r <= module_disable_lock_nxt;
        end
    end

    // Test port bits need no unlock; both come up set
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            test_port_enable_r <= 1'(`DCR_CTRL_RST >> `DCR_CTRL_TEST_EN_BIT);
            two_wire_test_out_use_r <= 1'(`DCR_CTRL_RST >> `DCR_CTRL_TDO_USE_BIT);
        end else if (ctrl_wr_w) begin
            test_port_enable_r <= reg_req_i.wdata[`DCR_CTRL_TEST_EN_BIT];
            two_wire_test_out_use_r <= reg_req_i.wdata[`DCR_CTRL_TDO_USE_BIT];
        end
    end

    assign test_port_enable_o = test_port_enable_r;
    assign two_wire_test_out_use_o = two_wire_test_out_use_r;

    // Handshake gates towards the mapping and disable register files
    assign pin_map_wr_accept_o = lock_req_i.pin_map_wr && !pin_map_lock_r;
    assign module_disable_wr_accept_o = lock_req_i.module_disable_wr && !module_disable_lock_r;

    // ----------------------------------------
    // Brown-out input synchroniser and flag
    // ----------------------------------------
    logic [2:0] bo_sync_r;
    logic bo_level_r;
    logic bo_flag_r;

    // The comparator is asynchronous; the level moves only when the
    // second and third stages agree, which filters single-stage noise
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bo_sync_r <= '0;
            bo_level_r <= 1'b0;
        end else begin
            bo_sync_r <= {bo_sync_r[1:0], supply_low_i};
            if (bo_sync_r[1] == bo_sync_r[2]) begin
                bo_level_r <= bo_sync_r[2];
            end
        end
    end

    wire bo_agree_w = (bo_sync_r[1] == bo_sync_r[2]);
    wire bo_event_w = bo_agree_w && bo_sync_r[2] && !bo_level_r;
    wire rcause_wr_w = reg_req_i.wr && hit(reg_req_i, `DCR_IDX_RCAUSE);

    // Set wins over a software clear in the same cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bo_flag_r <= 1'b0;
            brownout_reset_o <= 1'b0;
        end else begin
            brownout_reset_o <= bo_event_w;
            if (bo_event_w) begin
                bo_flag_r <= 1'b1;
            end else if (rcause_wr_w) begin
                bo_flag_r <= reg_req_i.wdata[`DCR_RCAUSE_BO_BIT];
            end
        end
    end

    // ----------------------------------------
    // Regulator start-up delay
    // ----------------------------------------
    // A brown-out is itself a power-down, so it also rearms the wait
    wire resume_w = power_resume_i || bo_event_w;

    dcr_startup_delay #(
        .DELAY_CYC(STARTUP_CYC)
    ) u_delay (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .restart_i(resume_w),
        .exec_enable_o(exec_enable_o)
    );

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    wire [31:0] ctrl_rd_w = (32'h0000_0000
        | ({31'h0, pin_map_lock_r} << `DCR_CTRL_PIN_LOCK_BIT)
        | ({31'h0, module_disable_lock_r} << `DCR_CTRL_MOD_LOCK_BIT)
        | ({31'h0, test_port_enable_r} << `DCR_CTRL_TEST_EN_BIT)
        | ({31'h0, two_wire_test_out_use_r} << `DCR_CTRL_TDO_USE_BIT)
        | `DCR_CTRL_ONES);
    wire [31:0] ident_rd_w = {SILICON_REV, DEVICE_IDENTITY};
    wire [31:0] rcause_rd_w = {31'h0, bo_flag_r} << `DCR_RCAUSE_BO_BIT;

    // Unmapped indices read as zero
    wire [31:0] rd_mux_w =
        hit(reg_req_i, `DCR_IDX_CFG2) ? cfg2_r :
        hit(reg_req_i, `DCR_IDX_CFG3) ? cfg3_r :
        hit(reg_req_i, `DCR_IDX_CTRL) ? ctrl_rd_w :
        hit(reg_req_i, `DCR_IDX_IDENT) ? ident_rd_w :
        hit(reg_req_i, `DCR_IDX_RCAUSE) ? rcause_rd_w : 32'h0;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= '0;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_req_i.rd;
            if (reg_req_i.rd) begin
                reg_rdata_o <= rd_mux_w;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_DIV_TOP_CODE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cfg_loaded_r && pll_input_div_sel == 3'h7) |=> cfg_o.pll_input_div_ratio == 4'hc)
        else $error("top divider code does not give ratio 12");

    AST_DIV_SIX_CODE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cfg_loaded_r && pll_input_div_sel == 3'h6) |=> cfg_o.pll_input_div_ratio == 4'ha)
        else $error("divider code 6 does not give ratio 10");

    AST_USB_OWNERS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cfg_loaded_r |=> (cfg_o.usb_power_pin_owner == cfg3_r[31]) && (cfg_o.usb_id_pin_owner == cfg3_r[30]))
        else $error("USB pin owner does not follow the config word");

    AST_PIN_LOCK_GATE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pin_map_lock_r |-> !pin_map_wr_accept_o)
        else $error("pin mapping write accepted while locked");

    AST_MOD_LOCK_GATE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (lock_req_i.module_disable_wr && !module_disable_lock_r) |-> module_disable_wr_accept_o)
        else $error("module disable write refused while unlocked");

    AST_LOCK_NEEDS_UNLOCK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !(ctrl_wr_w && sys_unlocked_i) |=> $stable(pin_map_lock_r) && $stable(module_disable_lock_r))
        else $error("lock bit moved without the unlock sequence");

    AST_ONE_WAY_STICKS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (pin_map_single_change && pin_map_lock_r) |=> pin_map_lock_r [*3])
        else $error("one-way pin mapping lock cleared");

    AST_CTRL_READBACK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (reg_req_i.rd && hit(reg_req_i, `DCR_IDX_CTRL))
            |=> reg_rvalid_o && reg_rdata_o[2:1] == 2'b11 && reg_rdata_o[31:14] == 18'h0
                && reg_rdata_o[11:4] == 8'h0)
        else $error("control register unused bits read wrong");

    AST_IDENT_READ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (reg_req_i.rd && hit(reg_req_i, `DCR_IDX_IDENT))
            |=> reg_rdata_o == {SILICON_REV, DEVICE_IDENTITY})
        else $error("identity register read wrong value");

    AST_BROWNOUT_FLAG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        bo_event_w |=> brownout_reset_o && bo_flag_r ##1 !brownout_reset_o)
        else $error("brown-out did not pulse reset and set the flag");

    AST_CFG_FROZEN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cfg_loaded_r && reg_req_i.wr) |=> $stable(cfg3_r) && $stable(cfg2_r))
        else $error("config word changed by a run-time write");

    // A frozen module lock must survive any clearing write
    AST_MOD_ONE_WAY_STICKS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (module_disable_single_change && module_disable_lock_r) |=> module_disable_lock_r)
        else $error("one-way module disable lock cleared");

    // Test port bits follow every control write, unlocked or not
    AST_TEST_BITS_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ctrl_wr_w |=> test_port_enable_o == $past(reg_req_i.wdata[`DCR_CTRL_TEST_EN_BIT])
            && two_wire_test_out_use_o == $past(reg_req_i.wdata[`DCR_CTRL_TDO_USE_BIT]))
        else $error("test port bits did not take the written value");

    AST_USER_ID_OUT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cfg_loaded_r |=> user_identifier_o == cfg3_r[15:0])
        else $error("user identifier output does not follow the config word");

    // The six low codes are a plain one-step ladder
    AST_DIV_LOW_CODES: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cfg_loaded_r && pll_input_div_sel < 3'h6) |=> cfg_o.pll_input_div_ratio == {1'b0, pll_input_div_sel} + 4'h1)
        else $error("low divider code gives the wrong ratio");

endmodule // dcr_top

//--- dcr_defines.svh
`ifndef DCR_DEFINES_SVH
`define DCR_DEFINES_SVH

// ----------------------------------------
// Register indices on the register port
// ----------------------------------------
`define DCR_IDX_CFG2 3'h0
`define DCR_IDX_CFG3 3'h1
`define DCR_IDX_CTRL 3'h2
`define DCR_IDX_IDENT 3'h3
`define DCR_IDX_RCAUSE 3'h4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DCR_CFG2_PLLDIV_LSB 0
`define DCR_CFG3_USB_PWR_BIT 31
`define DCR_CFG3_USB_ID_BIT 30
`define DCR_CFG3_PIN_ONCE_BIT 29
`define DCR_CFG3_MOD_ONCE_BIT 28
`define DCR_CFG3_RSVD_MSB 27
`define DCR_CFG3_RSVD_LSB 16
`define DCR_CTRL_PIN_LOCK_BIT 13
`define DCR_CTRL_MOD_LOCK_BIT 12
`define DCR_CTRL_TEST_EN_BIT 3
`define DCR_CTRL_TDO_USE_BIT 0
`define DCR_RCAUSE_BO_BIT 1

// ----------------------------------------
// Reset and fixed read values
// ----------------------------------------
`define DCR_CTRL_RST 32'h0000_0009
`define DCR_CTRL_ONES 32'h0000_0006
`define DCR_CTRL_WMASK 32'h0000_0009

// ----------------------------------------
// Timing
// ----------------------------------------
`define DCR_CLK_PERIOD_NS 20
`define DCR_STARTUP_NS 10000

`endif

//--- dcr_pkg.sv
package dcr_pkg;

    // Register port request, one per cycle
    typedef struct packed {
        logic [2:0] addr;
        logic wr;
        logic rd;
        logic [31:0] wdata;
    } dcr_reg_req_t;

    // Requests from the pin-mapping and module-disable register files
    typedef struct packed {
        logic pin_map_wr;
        logic module_disable_wr;
    } dcr_lock_req_t;

    // Decoded hardware configuration
    typedef struct packed {
        logic [3:0] pll_input_div_ratio;
        logic usb_power_pin_owner;
        logic usb_id_pin_owner;
        logic pin_map_single_change;
        logic module_disable_single_change;
    } dcr_cfg_t;

    typedef enum logic [1:0] {
        DCR_ST_HOLD = 2'b01,
        DCR_ST_RUN = 2'b10
    } dcr_state_t;

endpackage

//--- dcr_startup_delay.sv
`timescale 1ns/100ps
`include "dcr_defines.svh"

module dcr_startup_delay #(
    parameter int unsigned DELAY_CYC = 500
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic restart_i,
    output logic exec_enable_o
);
    import dcr_pkg::*;

    localparam int CW = $clog2(DELAY_CYC + 1);

    dcr_state_t state_r;
    dcr_state_t state_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    wire done_w = (cnt_r == CW'(DELAY_CYC - 1));

    // ----------------------------------------
    // Hold execution until the regulator has settled
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            DCR_ST_HOLD: begin
                cnt_nxt = cnt_r + CW'(1);
                if (done_w) begin
                    state_nxt = DCR_ST_RUN;
                end
            end
            DCR_ST_RUN: begin
                cnt_nxt = '0;
            end
            default: begin
                state_nxt = DCR_ST_HOLD;
                cnt_nxt = '0;
            end
        endcase
        // Any resume from power-down starts the wait over
        if (restart_i) begin
            state_nxt = DCR_ST_HOLD;
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= DCR_ST_HOLD;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Registered so the enable never glitches
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            exec_enable_o <= 1'b0;
        end else begin
            exec_enable_o <= (state_nxt == DCR_ST_RUN);
        end
    end

    AST_RESTART_HOLDS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        restart_i |=> !exec_enable_o [*2])
        else $error("execution enabled too soon after a resume");

endmodule // dcr_startup_delay

//--- tb.sv
`timescale 1ns/100ps
`include "dcr_defines.svh"

module tb;
    import dcr_pkg::*;

    // ----------------------------------------
    // Bench set-up
    // ----------------------------------------
    // Short start-up delay keeps every wait for the enable brief
    localparam int unsigned STARTUP_CYC = 8;
    localparam logic [3:0] REV = 4'h3; // Arbitrary revision code
    localparam logic [27:0] IDENT = 28'h123_4567; // Arbitrary identity code

    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    dcr_reg_req_t reg_req_i = '0;
    logic [31:0] reg_rdata_o;
    logic reg_rvalid_o;
    logic sys_unlocked_i = 1'b0;
    logic [31:0] nv_cfg2_i = 32'hffff_fff8;
    logic [31:0] nv_cfg3_i = 32'h0fff_0000;
    dcr_lock_req_t lock_req_i = '0;
    logic pin_map_wr_accept_o;
    logic module_disable_wr_accept_o;
    dcr_cfg_t cfg_o;
    logic [15:0] user_identifier_o;
    logic test_port_enable_o;
    logic two_wire_test_out_use_o;
    logic supply_low_i = 1'b0;
    logic brownout_reset_o;
    logic power_resume_i = 1'b0;
    logic exec_enable_o;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc_cnt = 0;
    logic [3:0] ratio_tab [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'ha, 4'hc};

    dcr_top #(.SILICON_REV(REV), .DEVICE_IDENTITY(IDENT), .STARTUP_CYC(STARTUP_CYC)) dcr_top_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .sys_unlocked_i(sys_unlocked_i), .nv_cfg2_i(nv_cfg2_i),
        .nv_cfg3_i(nv_cfg3_i), .lock_req_i(lock_req_i), .pin_map_wr_accept_o(pin_map_wr_accept_o),
        .module_disable_wr_accept_o(module_disable_wr_accept_o), .cfg_o(cfg_o),
        .user_identifier_o(user_identifier_o), .test_port_enable_o(test_port_enable_o),
        .two_wire_test_out_use_o(two_wire_test_out_use_o), .supply_low_i(supply_low_i),
        .brownout_reset_o(brownout_reset_o), .power_resume_i(power_resume_i), .exec_enable_o(exec_enable_o)
    );

    // Free-running 50 MHz clock
    always #10 clk_i = ~clk_i;

    // Hang guard: far above the few hundred cycles the tests need
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            $display("BAD timeout expected 0 seen 1");
            results();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Inputs move on the falling edge, so the rising edge always sees them settled
    task automatic reg_rd(input logic [2:0] a, output logic [31:0] d);
        @(negedge clk_i);
        reg_req_i = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 32'h0};
        @(negedge clk_i);
        reg_req_i = '0;
        chk("rvalid", 32'h1, {31'h0, reg_rvalid_o});
        d = reg_rdata_o;
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [31:0] v);
        @(negedge clk_i);
        reg_req_i = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
        @(negedge clk_i);
        reg_req_i = '0;
    endtask

    task automatic rd_chk(input string what, input logic [2:0] a, input logic [31:0] exp);
        logic [31:0] d;
        reg_rd(a, d);
        chk(what, exp, d);
    endtask

    // Both lock gates are combinational, so they are judged in the request cycle
    task automatic acc_chk(input logic pin_exp, input logic mod_exp);
        @(negedge clk_i);
        lock_req_i = '{pin_map_wr: 1'b1, module_disable_wr: 1'b1};
        #1;
        chk("pin_map_accept", {31'h0, pin_exp}, {31'h0, pin_map_wr_accept_o});
        chk("module_disable_accept", {31'h0, mod_exp}, {31'h0, module_disable_wr_accept_o});
        @(negedge clk_i);
        lock_req_i = '0;
    endtask

    task automatic do_reset(input logic [31:0] c2, input logic [31:0] c3);
        @(negedge clk_i);
        rst_n_i = 1'b0;
        nv_cfg2_i = c2;
        nv_cfg3_i = c3;
        sys_unlocked_i = 1'b0;
        repeat (4) @(negedge clk_i);
        rst_n_i = 1'b1;
    endtask

    // Counts cycles until execution is allowed again, bounded by lim
    task automatic wait_exec(input int lim);
        int n;
        n = 0;
        while (exec_enable_o !== 1'b1 && n < lim) begin
            @(negedge clk_i);
            n++;
        end
        chk("exec_enable", 32'h1, {31'h0, exec_enable_o});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_startup();
        do_reset(32'hffff_fff8, 32'h0fff_0000);
        chk("test_port_en", 32'h1, {31'h0, test_port_enable_o});
        chk("two_wire", 32'h1, {31'h0, two_wire_test_out_use_o});
        repeat (STARTUP_CYC - 1) @(negedge clk_i);
        chk("exec_early", 32'h0, {31'h0, exec_enable_o});
        @(negedge clk_i);
        chk("exec_on_time", 32'h1, {31'h0, exec_enable_o});
        rd_chk("ctrl_reset", `DCR_IDX_CTRL, 32'h0000_000f);
        $display("done startup");
    endtask

    // Every divider code, with owner and one-way bits varied alongside
    task automatic t_decode();
        logic [31:0] c2;
        logic [31:0] c3;
        for (int i = 0; i < 8; i++) begin
            c2 = {29'h1fff_fff8 >> 3, i[2:0]};
            c3 = {i[0], i[1], i[2], ~i[2], 12'hfff, 16'ha5c3 ^ 16'(i * 16'h1111)};
            do_reset(c2, c3);
            repeat (3) @(negedge clk_i);
            chk("pll_div", {28'h0, ratio_tab[i]}, {28'h0, cfg_o.pll_input_div_ratio});
            chk("usb_pwr_owner", {31'h0, c3[31]}, {31'h0, cfg_o.usb_power_pin_owner});
            chk("usb_id_owner", {31'h0, c3[30]}, {31'h0, cfg_o.usb_id_pin_owner});
            chk("pin_once", {31'h0, c3[29]}, {31'h0, cfg_o.pin_map_single_change});
            chk("mod_once", {31'h0, c3[28]}, {31'h0, cfg_o.module_disable_single_change});
            chk("user_id", {16'h0, c3[15:0]}, {16'h0, user_identifier_o});
            reg_wr(`DCR_IDX_CFG2, ~c2);
            reg_wr(`DCR_IDX_CFG3, ~c3);
            reg_wr(`DCR_IDX_IDENT, 32'h0);
            rd_chk("cfg2_read", `DCR_IDX_CFG2, c2);
            rd_chk("cfg3_read", `DCR_IDX_CFG3, c3);
            rd_chk("ident_read", `DCR_IDX_IDENT, {REV, IDENT});
            rd_chk("unmapped_read", 3'h5, 32'h0);
        end
        $display("done decode");
    endtask

    // Lock bits need the unlock; one-way mode keeps them set until reset
    task automatic t_locks(input logic one_way);
        logic [31:0] held;
        do_reset(32'hffff_fff8, {2'b11, one_way, one_way, 12'hfff, 16'h0001});
        repeat (3) @(negedge clk_i);
        acc_chk(1'b1, 1'b1);
        reg_wr(`DCR_IDX_CTRL, 32'h0000_3009);
        rd_chk("ctrl_no_unlock", `DCR_IDX_CTRL, 32'h0000_000f);
        acc_chk(1'b1, 1'b1);
        sys_unlocked_i = 1'b1;
        reg_wr(`DCR_IDX_CTRL, 32'hffff_f009);
        rd_chk("ctrl_locked", `DCR_IDX_CTRL, 32'h0000_300f);
        acc_chk(1'b0, 1'b0);
        reg_wr(`DCR_IDX_CTRL, 32'h0000_0000);
        held = one_way ? 32'h0000_3006 : 32'h0000_0006;
        rd_chk("ctrl_clear", `DCR_IDX_CTRL, held);
        chk("test_port_off", 32'h0, {31'h0, test_port_enable_o});
        chk("two_wire_off", 32'h0, {31'h0, two_wire_test_out_use_o});
        acc_chk(!one_way, !one_way);
        sys_unlocked_i = 1'b0;
        reg_wr(`DCR_IDX_CTRL, 32'h0000_0009);
        rd_chk("ctrl_test_bits", `DCR_IDX_CTRL, held | 32'h0000_0009);
        $display("done locks one_way=%0d", one_way);
    endtask

    task automatic t_power();
        logic [31:0] d;
        int n;
        do_reset(32'hffff_fff8, 32'h0fff_0000);
        repeat (STARTUP_CYC + 3) @(negedge clk_i);
        supply_low_i = 1'b1;
        n = 0;
        while (brownout_reset_o !== 1'b1 && n < 8) begin
            @(negedge clk_i);
            n++;
        end
        chk("brownout_pulse", 32'h1, {31'h0, brownout_reset_o});
        @(negedge clk_i);
        chk("brownout_one_cycle", 32'h0, {31'h0, brownout_reset_o});
        chk("exec_after_bo", 32'h0, {31'h0, exec_enable_o});
        reg_rd(`DCR_IDX_RCAUSE, d);
        chk("bo_flag", 32'h1, {31'h0, d[`DCR_RCAUSE_BO_BIT]});
        wait_exec(STARTUP_CYC + 2);
        reg_wr(`DCR_IDX_RCAUSE, 32'h0);
        reg_rd(`DCR_IDX_RCAUSE, d);
        chk("bo_flag_clear", 32'h0, {31'h0, d[`DCR_RCAUSE_BO_BIT]});
        supply_low_i = 1'b0;
        @(negedge clk_i);
        power_resume_i = 1'b1;
        @(negedge clk_i);
        power_resume_i = 1'b0;
        chk("exec_resume_off", 32'h0, {31'h0, exec_enable_o});
        repeat (STARTUP_CYC - 2) @(negedge clk_i);
        chk("exec_resume_hold", 32'h0, {31'h0, exec_enable_o});
        wait_exec(4);
        $display("done power");
    endtask

    // ----------------------------------------
    // Main sequence and verdict
    // ----------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        t_startup();
        t_decode();
        t_locks(1'b0);
        t_locks(1'b1);
        t_power();
        results();
    end
endmodule // tb
